// file: logic/lpsd_pkg.sv
// Summary of operation
// - Device samples all inputs on rising clock
// - Four banks, 134,217,728 bits each
// - Sixteen-bit: 8192 rows, 1K columns, 16-bit words
// - Thirty-two-bit: 8192 rows, 512 columns, 32-bit words
// - Reduced page: 16,384 rows, 256 columns
// - Device generates burst column addresses internally
// - New column address accepted every cycle
// - Access one bank while another precharges
// - Sixteen-bit low/high masks govern DQ[7:0], DQ[15:8]
// - Four masks govern lanes DQ[7:0] to DQ[31:24]
// - Row on A[12:0], reduced page A[13:0]
// - Column on A[9:0], A[8:0] or A[7:0]
// - Chip select high masks every command
// - Strobes plus chip select encode the command
package lpsd_pkg;
  localparam int LPSD_BANKS = 4;
  localparam int LPSD_BANK_BITS = 2;
  localparam int LPSD_ADDR_PINS = 14;
  localparam int LPSD_LANE_W = 8;
  localparam int LPSD_LANES_MAX = 4;
  localparam int LPSD_DQ_MAX = 32;
  localparam int LPSD_ROW_BITS_STD = 13;
  localparam int LPSD_ROW_BITS_RP = 14;
  localparam int LPSD_COL_BITS_X16 = 10;
  localparam int LPSD_COL_BITS_X32 = 9;
  localparam int LPSD_COL_BITS_RP = 8;
  localparam int LPSD_DQ_W_X16 = 16;
  localparam int LPSD_DQ_W_X32 = 32;
  localparam int LPSD_BURST_LEN = 4;
  localparam int LPSD_RD_PIPE = 2;
  // Edges from the controller's command edge to its data sample edge
  localparam int LPSD_RD_LAT = LPSD_RD_PIPE + 3;
  localparam int LPSD_CLK_NS = 10;
  localparam int LPSD_T_RP_NS = 20;
  localparam int LPSD_T_RCD_NS = 20;
  localparam int LPSD_T_RP_CYC = (LPSD_T_RP_NS + LPSD_CLK_NS - 1) / LPSD_CLK_NS;
  localparam int LPSD_T_RCD_CYC = (LPSD_T_RCD_NS + LPSD_CLK_NS - 1) / LPSD_CLK_NS;
  localparam int LPSD_TMR_W = 4;
  typedef enum logic [1:0] {
    LPSD_X16 = 2'h0,
    LPSD_X32 = 2'h1,
    LPSD_X32RP = 2'h2
  } lpsd_geom_t;
  // Encoded as {row strobe, column strobe, write enable}, all active low
  typedef enum logic [2:0] {
    LPSD_CMD_PRE = 3'h2,
    LPSD_CMD_ACT = 3'h3,
    LPSD_CMD_WR = 3'h4,
    LPSD_CMD_RD = 3'h5,
    LPSD_CMD_NOP = 3'h7
  } lpsd_cmd_t;
  function automatic int lpsd_row_bits(lpsd_geom_t g);
    return (g == LPSD_X32RP) ? LPSD_ROW_BITS_RP : LPSD_ROW_BITS_STD;
  endfunction
  function automatic int lpsd_col_bits(lpsd_geom_t g);
    case (g)
      LPSD_X16: return LPSD_COL_BITS_X16;
      LPSD_X32: return LPSD_COL_BITS_X32;
      default: return LPSD_COL_BITS_RP;
    endcase
  endfunction
  function automatic int lpsd_dq_w(lpsd_geom_t g);
    return (g == LPSD_X16) ? LPSD_DQ_W_X16 : LPSD_DQ_W_X32;
  endfunction
  function automatic int lpsd_ua_bits(lpsd_geom_t g);
    return LPSD_BANK_BITS + lpsd_row_bits(g) + lpsd_col_bits(g);
  endfunction
endpackage

// file: logic/lpsd_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lpsd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select_bit0;
  logic bank_select_bit1;
  logic [lpsd_pkg::LPSD_ADDR_PINS-1:0] addr;
  logic lane0_byte_mask;
  logic lane1_byte_mask;
  logic lane2_byte_mask;
  logic lane3_byte_mask;
  logic [lpsd_pkg::LPSD_DQ_MAX-1:0] ctl_dq_out;
  logic [lpsd_pkg::LPSD_LANES_MAX-1:0] ctl_dq_oe;
  logic [lpsd_pkg::LPSD_DQ_MAX-1:0] dev_dq_out;
  logic [lpsd_pkg::LPSD_LANES_MAX-1:0] dev_dq_oe;
  wire [lpsd_pkg::LPSD_DQ_MAX-1:0] dq;
  // On the sixteen-bit part the two low lanes carry the low and high masks
  wire low_byte_mask;
  wire high_byte_mask;
  assign low_byte_mask = lane0_byte_mask;
  assign high_byte_mask = lane1_byte_mask;
  // Shared data wire: the device wins, an undriven lane reads zero
  for (genvar l = 0; l < lpsd_pkg::LPSD_LANES_MAX; l++) begin : g_lane
    assign dq[l*8 +: 8] = dev_dq_oe[l] ? dev_dq_out[l*8 +: 8] :
                          ctl_dq_oe[l] ? ctl_dq_out[l*8 +: 8] : 8'h00;
  end
  modport dev_mp (
    input cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1, addr,
    input low_byte_mask, high_byte_mask,
    input lane0_byte_mask, lane1_byte_mask, lane2_byte_mask, lane3_byte_mask,
    input dq,
    output dev_dq_out, dev_dq_oe
  );
  modport ctl_mp (
    output cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1, addr,
    output lane0_byte_mask, lane1_byte_mask, lane2_byte_mask, lane3_byte_mask,
    output ctl_dq_out, ctl_dq_oe,
    input dq
  );
endinterface
`default_nettype wire

// file: logic/lpsd_fifo2.sv
`timescale 1ns/100ps
`default_nettype none
module lpsd_fifo2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] store_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic ready_reg, ready_next;
  logic push, pop;

  assign in_ready = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = store_reg[rd_ptr_reg];

  always_comb begin
    push = in_valid && ready_reg;
    pop = out_valid && out_ready;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ready_next = (count_next < (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: logic/lpsd_dev.sv
`timescale 1ns/100ps
`default_nettype none
module lpsd_dev #(
  parameter lpsd_pkg::lpsd_geom_t GEOM = lpsd_pkg::LPSD_X16,
  parameter int STORE_AW = lpsd_pkg::lpsd_ua_bits(GEOM)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pins toward the controller
  lpsd_if.dev_mp pins,
  // Status
  output logic [lpsd_pkg::LPSD_BANKS-1:0] bank_open
);
  import lpsd_pkg::*;
  localparam int RB = lpsd_row_bits(GEOM);
  localparam int CB = lpsd_col_bits(GEOM);
  localparam int DQW = lpsd_dq_w(GEOM);
  localparam int LN = DQW / LPSD_LANE_W;
  localparam int IW = lpsd_ua_bits(GEOM);
  localparam int BLB = $clog2(LPSD_BURST_LEN);
  localparam int LW = BLB + 1;
  localparam int P = LPSD_RD_PIPE;

  // Input capture
  logic cs_n_reg, cs_n_next;
  logic [2:0] cmd_reg, cmd_next;
  logic [LPSD_BANK_BITS-1:0] ba_reg, ba_next;
  logic [LPSD_ADDR_PINS-1:0] a_reg, a_next;
  logic [DQW-1:0] dq_reg, dq_next;
  logic [LN-1:0] mask_reg, mask_next;
  logic [LPSD_LANES_MAX-1:0] mask_pins;

  always_comb begin
    if (GEOM == LPSD_X16) begin
      mask_pins = {2'h3, pins.high_byte_mask, pins.low_byte_mask};
    end else begin
      mask_pins = {pins.lane3_byte_mask, pins.lane2_byte_mask,
                   pins.lane1_byte_mask, pins.lane0_byte_mask};
    end
    cs_n_next = pins.cs_n;
    cmd_next = {pins.ras_n, pins.cas_n, pins.we_n};
    ba_next = {pins.bank_select_bit1, pins.bank_select_bit0};
    a_next = pins.addr;
    dq_next = pins.dq[DQW-1:0];
    mask_next = mask_pins[LN-1:0];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_n_reg <= 1'b1;
      cmd_reg <= LPSD_CMD_NOP;
      ba_reg <= '0;
      a_reg <= '0;
      dq_reg <= '0;
      mask_reg <= '1;
    end else begin
      cs_n_reg <= cs_n_next;
      cmd_reg <= cmd_next;
      ba_reg <= ba_next;
      a_reg <= a_next;
      dq_reg <= dq_next;
      mask_reg <= mask_next;
    end
  end

  // Command decode
  logic cmd_ok;
  lpsd_cmd_t cmd;
  logic col_cmd, pre_cmd;
  logic [LPSD_BANKS-1:0] open_vec;
  logic [RB-1:0] row_vec [LPSD_BANKS];

  always_comb begin
    cmd_ok = !cs_n_reg;
    cmd = lpsd_cmd_t'(cmd_reg);
    col_cmd = cmd_ok && (cmd == LPSD_CMD_RD || cmd == LPSD_CMD_WR) && open_vec[ba_reg];
    pre_cmd = cmd_ok && (cmd == LPSD_CMD_PRE);
  end

  // Per-bank row state and precharge timer; banks run independently
  for (genvar b = 0; b < LPSD_BANKS; b++) begin : g_bank
    logic open_reg, open_next;
    logic [RB-1:0] row_reg, row_next;
    logic [LPSD_TMR_W-1:0] trp_reg, trp_next;
    logic hit;

    always_comb begin
      hit = cmd_ok && (ba_reg == LPSD_BANK_BITS'(b));
      open_next = open_reg;
      row_next = row_reg;
      trp_next = (trp_reg != '0) ? trp_reg - 1'b1 : trp_reg;
      if (hit && cmd == LPSD_CMD_ACT && !open_reg && trp_reg == '0) begin
        open_next = 1'b1;
        row_next = a_reg[RB-1:0];
      end else if (hit && cmd == LPSD_CMD_PRE && open_reg) begin
        open_next = 1'b0;
        trp_next = LPSD_TMR_W'(LPSD_T_RP_CYC);
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        open_reg <= 1'b0;
        row_reg <= '0;
        trp_reg <= '0;
      end else begin
        open_reg <= open_next;
        row_reg <= row_next;
        trp_reg <= trp_next;
      end
    end

    assign open_vec[b] = open_reg;
    assign row_vec[b] = row_reg;
    assign bank_open[b] = open_reg;
  end

  // Burst engine: column commands start a burst, later beats count on
  logic [LW-1:0] left_reg, left_next;
  logic wr_reg, wr_next;
  logic [LPSD_BANK_BITS-1:0] bbank_reg, bbank_next;
  logic [RB-1:0] brow_reg, brow_next;
  logic [CB-1:0] bcol_reg, bcol_next;
  logic acc;
  logic [IW-1:0] full_idx;
  logic [STORE_AW-1:0] idx;
  logic [LN-1:0] oe0_next;

  always_comb begin
    acc = 1'b0;
    wr_next = wr_reg;
    bbank_next = bbank_reg;
    brow_next = brow_reg;
    bcol_next = bcol_reg;
    left_next = '0;
    if (col_cmd) begin
      acc = 1'b1;
      wr_next = (cmd == LPSD_CMD_WR);
      bbank_next = ba_reg;
      brow_next = row_vec[ba_reg];
      bcol_next = a_reg[CB-1:0];
      left_next = LW'(LPSD_BURST_LEN - 1);
    end else if (left_reg != '0 && !(pre_cmd && ba_reg == bbank_reg)) begin
      acc = 1'b1;
      bcol_next = {bcol_reg[CB-1:BLB], bcol_reg[BLB-1:0] + 1'b1};
      left_next = left_reg - 1'b1;
    end
    // Bank sits between row and column so truncation drops high rows first
    full_idx = {brow_next, bbank_next, bcol_next};
    idx = STORE_AW'(full_idx);
    oe0_next = (acc && !wr_next) ? ~mask_reg : '0;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      left_reg <= '0;
      wr_reg <= 1'b0;
      bbank_reg <= '0;
      brow_reg <= '0;
      bcol_reg <= '0;
    end else begin
      left_reg <= left_next;
      wr_reg <= wr_next;
      bbank_reg <= bbank_next;
      brow_reg <= brow_next;
      bcol_reg <= bcol_next;
    end
  end

  // Storage array and read port
  logic [DQW-1:0] mem [2**STORE_AW];
  logic [DQW-1:0] rdat_reg;

  always_ff @(posedge mclk) begin
    if (acc && wr_next) begin
      for (int l = 0; l < LN; l++) begin
        if (!mask_reg[l]) begin
          mem[idx][l*8 +: 8] <= dq_reg[l*8 +: 8];
        end
      end
    end
    rdat_reg <= mem[idx];
  end

  // Output pipeline toward the data pins
  logic [LN-1:0] oe0_reg;
  logic [DQW-1:0] pd_reg [P];
  logic [DQW-1:0] pd_next [P];
  logic [LN-1:0] po_reg [P];
  logic [LN-1:0] po_next [P];

  always_comb begin
    pd_next[0] = rdat_reg;
    po_next[0] = oe0_reg;
    for (int s = 1; s < P; s++) begin
      pd_next[s] = pd_reg[s-1];
      po_next[s] = po_reg[s-1];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oe0_reg <= '0;
      for (int s = 0; s < P; s++) begin
        pd_reg[s] <= '0;
        po_reg[s] <= '0;
      end
    end else begin
      oe0_reg <= oe0_next;
      for (int s = 0; s < P; s++) begin
        pd_reg[s] <= pd_next[s];
        po_reg[s] <= po_next[s];
      end
    end
  end

  assign pins.dev_dq_out = LPSD_DQ_MAX'(pd_reg[P-1]);
  assign pins.dev_dq_oe = LPSD_LANES_MAX'(po_reg[P-1]);
endmodule
`default_nettype wire

// file: logic/lpsd_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module lpsd_ctl #(
  parameter lpsd_pkg::lpsd_geom_t GEOM = lpsd_pkg::LPSD_X16,
  parameter int UAW = lpsd_pkg::lpsd_ua_bits(GEOM)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Word requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [UAW-1:0] req_addr,
  input wire logic [lpsd_pkg::LPSD_DQ_MAX-1:0] req_wdata,
  input wire logic [lpsd_pkg::LPSD_LANES_MAX-1:0] req_mask,
  // Read return
  output logic rd_valid,
  output logic [lpsd_pkg::LPSD_DQ_MAX-1:0] rd_data,
  // Pins toward the memory
  lpsd_if.ctl_mp pins
);
  import lpsd_pkg::*;
  localparam int RB = lpsd_row_bits(GEOM);
  localparam int CB = lpsd_col_bits(GEOM);
  localparam int LN = lpsd_dq_w(GEOM) / LPSD_LANE_W;
  localparam int FW = 1 + UAW + LPSD_DQ_MAX + LPSD_LANES_MAX;

  logic h_valid, pop, h_wr;
  logic [FW-1:0] h_data;
  logic [UAW-1:0] h_addr;
  logic [LPSD_DQ_MAX-1:0] h_wdata;
  logic [LPSD_LANES_MAX-1:0] h_mask;
  logic [CB-1:0] h_col;
  logic [LPSD_BANK_BITS-1:0] h_bank;
  logic [RB-1:0] h_row;

  lpsd_fifo2 #(.W(FW), .DEPTH(2)) u_req (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_addr, req_wdata, req_mask}),
    .out_valid(h_valid),
    .out_ready(pop),
    .out_data(h_data)
  );

  // Address split: row above bank above column, so neighbours interleave
  assign {h_wr, h_addr, h_wdata, h_mask} = h_data;
  assign h_col = h_addr[CB-1:0];
  assign h_bank = h_addr[CB +: LPSD_BANK_BITS];
  assign h_row = h_addr[CB+LPSD_BANK_BITS +: RB];

  logic [LPSD_BANKS-1:0] open_vec;
  logic [RB-1:0] row_vec [LPSD_BANKS];
  logic [LPSD_BANKS-1:0] idle_vec;
  logic [LPSD_RD_LAT-1:0] trk_reg, trk_next;
  logic do_col, do_pre, do_act;

  always_comb begin
    do_col = h_valid && idle_vec[h_bank] && open_vec[h_bank] && row_vec[h_bank] == h_row;
    // A write waits until no read data is still due on the shared wires
    if (h_wr && trk_reg != '0) begin
      do_col = 1'b0;
    end
    do_pre = h_valid && idle_vec[h_bank] && open_vec[h_bank] && row_vec[h_bank] != h_row;
    do_act = h_valid && idle_vec[h_bank] && !open_vec[h_bank];
    pop = do_col;
  end

  // Per-bank open row and timer; a precharging bank holds the head request, so the whole queue waits
  for (genvar b = 0; b < LPSD_BANKS; b++) begin : g_bank
    logic open_reg, open_next;
    logic [RB-1:0] row_reg, row_next;
    logic [LPSD_TMR_W-1:0] tmr_reg, tmr_next;
    logic sel;

    always_comb begin
      sel = (h_bank == LPSD_BANK_BITS'(b));
      open_next = open_reg;
      row_next = row_reg;
      tmr_next = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
      if (sel && do_act) begin
        open_next = 1'b1;
        row_next = h_row;
        tmr_next = LPSD_TMR_W'(LPSD_T_RCD_CYC);
      end else if (sel && do_pre) begin
        open_next = 1'b0;
        tmr_next = LPSD_TMR_W'(LPSD_T_RP_CYC);
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        open_reg <= 1'b0;
        row_reg <= '0;
        tmr_reg <= '0;
      end else begin
        open_reg <= open_next;
        row_reg <= row_next;
        tmr_reg <= tmr_next;
      end
    end

    assign open_vec[b] = open_reg;
    assign row_vec[b] = row_reg;
    assign idle_vec[b] = (tmr_reg == '0);
  end

  // Pin drivers
  logic cs_n_reg, cs_n_next;
  logic [2:0] cmd_reg, cmd_next;
  logic [LPSD_BANK_BITS-1:0] ba_reg, ba_next;
  logic [LPSD_ADDR_PINS-1:0] a_reg, a_next;
  logic [LPSD_LANES_MAX-1:0] mask_reg, mask_next, oe_reg, oe_next;
  logic [LPSD_DQ_MAX-1:0] wd_reg, wd_next;
  logic rdv_reg, rdv_next;
  logic [LPSD_DQ_MAX-1:0] rdd_reg, rdd_next;

  always_comb begin
    cs_n_next = !(do_col || do_pre || do_act);
    cmd_next = LPSD_CMD_NOP;
    ba_next = h_bank;
    a_next = '0;
    // Masks stay high outside a column command so burst tails do nothing
    mask_next = '1;
    oe_next = '0;
    wd_next = h_wdata;
    if (do_act) begin
      cmd_next = LPSD_CMD_ACT;
      a_next = LPSD_ADDR_PINS'(h_row);
    end else if (do_pre) begin
      cmd_next = LPSD_CMD_PRE;
    end else if (do_col) begin
      cmd_next = h_wr ? LPSD_CMD_WR : LPSD_CMD_RD;
      a_next = LPSD_ADDR_PINS'(h_col);
      mask_next = h_mask;
      oe_next = h_wr ? LPSD_LANES_MAX'({LN{1'b1}}) : '0;
    end
    trk_next = {trk_reg[LPSD_RD_LAT-2:0], do_col && !h_wr};
    rdv_next = trk_reg[LPSD_RD_LAT-1];
    rdd_next = trk_reg[LPSD_RD_LAT-1] ? pins.dq : rdd_reg;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_n_reg <= 1'b1;
      cmd_reg <= LPSD_CMD_NOP;
      ba_reg <= '0;
      a_reg <= '0;
      mask_reg <= '1;
      oe_reg <= '0;
      wd_reg <= '0;
      trk_reg <= '0;
      rdv_reg <= 1'b0;
      rdd_reg <= '0;
    end else begin
      cs_n_reg <= cs_n_next;
      cmd_reg <= cmd_next;
      ba_reg <= ba_next;
      a_reg <= a_next;
      mask_reg <= mask_next;
      oe_reg <= oe_next;
      wd_reg <= wd_next;
      trk_reg <= trk_next;
      rdv_reg <= rdv_next;
      rdd_reg <= rdd_next;
    end
  end

  assign pins.cs_n = cs_n_reg;
  assign {pins.ras_n, pins.cas_n, pins.we_n} = cmd_reg;
  assign {pins.bank_select_bit1, pins.bank_select_bit0} = ba_reg;
  assign pins.addr = a_reg;
  assign {pins.lane3_byte_mask, pins.lane2_byte_mask,
          pins.lane1_byte_mask, pins.lane0_byte_mask} = mask_reg;
  assign pins.ctl_dq_out = wd_reg;
  assign pins.ctl_dq_oe = oe_reg;
  assign rd_valid = rdv_reg;
  assign rd_data = rdd_reg;
endmodule
`default_nettype wire

// file: dv/lpsd_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lpsd_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [13:0] addr,
  // Lane masks and data enables
  input wire logic lane0_byte_mask,
  input wire logic lane1_byte_mask,
  input wire logic [3:0] ctl_dq_oe,
  input wire logic [3:0] dev_dq_oe
);
  import lpsd_pkg::*;
  logic [1:0] bank;
  logic is_rd, is_wr, is_act, is_pre, is_col;
  logic [9:0] rd_hist_reg;
  logic [9:0] rd_hist_next;
  assign bank = {bank_select_bit1, bank_select_bit0};
  assign is_rd = !cs_n && {ras_n, cas_n, we_n} == LPSD_CMD_RD;
  assign is_wr = !cs_n && {ras_n, cas_n, we_n} == LPSD_CMD_WR;
  assign is_act = !cs_n && {ras_n, cas_n, we_n} == LPSD_CMD_ACT;
  assign is_pre = !cs_n && {ras_n, cas_n, we_n} == LPSD_CMD_PRE;
  assign is_col = is_rd || is_wr;
  // Recent read commands, so device drive can be traced to its cause
  always_comb begin
    rd_hist_next = {rd_hist_reg[8:0], is_rd};
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_hist_reg <= 10'h000;
    end else begin
      rd_hist_reg <= rd_hist_next;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_wr_drive;
    ctl_dq_oe != 4'h0 |-> is_wr;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("controller drives data outside a write");
  property p_wr_lanes;
    is_wr |-> ctl_dq_oe == 4'h3;
  endproperty
  a_wr_lanes: assert property (p_wr_lanes) else $error("write does not drive exactly the two low lanes");
  property p_mask_rest;
    !is_col |-> lane0_byte_mask && lane1_byte_mask;
  endproperty
  a_mask_rest: assert property (p_mask_rest) else $error("mask low outside a column command");
  property p_col_width;
    is_col |-> addr[13:10] == 4'h0;
  endproperty
  a_col_width: assert property (p_col_width) else $error("column wider than ten bits");
  property p_x16_lanes;
    dev_dq_oe[3:2] == 2'h0;
  endproperty
  a_x16_lanes: assert property (p_x16_lanes) else $error("device drives an upper lane");
  property p_dev_cause;
    dev_dq_oe != 4'h0 |-> rd_hist_reg != 10'h000;
  endproperty
  a_dev_cause: assert property (p_dev_cause) else $error("device drives without a read");
  property p_rd_answer;
    is_rd && !lane0_byte_mask |-> ##[2:6] dev_dq_oe[0];
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered on lane 0");
  property p_trp;
    is_act |-> !($past(is_pre) && $past(bank) == bank) && !($past(is_pre, 2) && $past(bank, 2) == bank);
  endproperty
  a_trp: assert property (p_trp) else $error("activate too soon after precharge");
  property p_trcd;
    is_col |-> !($past(is_act) && $past(bank) == bank);
  endproperty
  a_trcd: assert property (p_trcd) else $error("column too soon after activate");
  c_rd: cover property (is_rd);
  c_wr: cover property (is_wr ##1 is_wr);
  c_pre_act: cover property (is_pre ##[1:4] is_act);
endmodule
`default_nettype wire

// file: dv/lpsd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lpsd_tb_top;
  import lpsd_pkg::*;
  localparam lpsd_geom_t GEOM = LPSD_X16;
  localparam int UAW = lpsd_ua_bits(GEOM);
  logic mclk, nrst, req_valid, req_ready, req_write, rd_valid, seen_full;
  logic [UAW-1:0] req_addr;
  logic [31:0] req_wdata, rd_data;
  logic [3:0] req_mask, bank_open;
  logic [15:0] exp_q[$];
  int fails, compares;
  logic rp_valid, rp_ready, rp_write, rp_rdv;
  logic [23:0] rp_addr;
  logic [31:0] rp_wdata, rp_rdata;
  logic [3:0] rp_mask, rp_open;
  lpsd_if u_lpsd_if ();
  lpsd_ctl #(.GEOM(GEOM)) u_lpsd_ctl (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
    .rd_valid(rd_valid), .rd_data(rd_data), .pins(u_lpsd_if.ctl_mp));
  // Small store: index keeps column, bank and two row bits
  lpsd_dev #(.GEOM(GEOM), .STORE_AW(14)) u_lpsd_dev (.mclk(mclk), .nrst(nrst), .pins(u_lpsd_if.dev_mp),
    .bank_open(bank_open));
  // Reduced-page thirty-two-bit pair on its own link
  lpsd_if u_lpsd_if_rp ();
  lpsd_ctl #(.GEOM(LPSD_X32RP)) u_lpsd_ctl_rp (.mclk(mclk), .nrst(nrst), .req_valid(rp_valid), .req_ready(rp_ready),
    .req_write(rp_write), .req_addr(rp_addr), .req_wdata(rp_wdata), .req_mask(rp_mask),
    .rd_valid(rp_rdv), .rd_data(rp_rdata), .pins(u_lpsd_if_rp.ctl_mp));
  lpsd_dev #(.GEOM(LPSD_X32RP), .STORE_AW(12)) u_lpsd_dev_rp (.mclk(mclk), .nrst(nrst), .pins(u_lpsd_if_rp.dev_mp),
    .bank_open(rp_open));
  lpsd_properties u_lpsd_properties (.mclk(mclk), .nrst(nrst), .cs_n(u_lpsd_if.cs_n), .ras_n(u_lpsd_if.ras_n),
    .cas_n(u_lpsd_if.cas_n), .we_n(u_lpsd_if.we_n), .bank_select_bit0(u_lpsd_if.bank_select_bit0),
    .bank_select_bit1(u_lpsd_if.bank_select_bit1), .addr(u_lpsd_if.addr),
    .lane0_byte_mask(u_lpsd_if.lane0_byte_mask), .lane1_byte_mask(u_lpsd_if.lane1_byte_mask),
    .ctl_dq_oe(u_lpsd_if.ctl_dq_oe), .dev_dq_oe(u_lpsd_if.dev_dq_oe));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [24:0] ua(input logic [12:0] row, input logic [1:0] bank, input logic [9:0] col);
    return {row, bank, col};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Offer one request and hold it until the edge that takes it
  task automatic put(input logic w, input logic [24:0] a, input logic [15:0] d, input logic [1:0] m,
                     input logic [15:0] e);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = {16'h0000, d};
    req_mask = {2'h3, m};
    if (!w) exp_q.push_back(e);
    while (req_ready !== 1'b1 && n < 200) begin
      seen_full = 1'b1;
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 200) check(32'h0, 32'h1);
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [24:0] a, input logic [15:0] d, input logic [1:0] m);
    put(1'b1, a, d, m, 16'h0000);
  endtask
  task automatic rd(input logic [24:0] a, input logic [1:0] m, input logic [15:0] e);
    put(1'b0, a, 16'h0000, m, e);
  endtask
  // Reduced-page pair: a read lowers valid and waits for its own answer
  task automatic put_rp(input logic w, input logic [23:0] a, input logic [31:0] d, input logic [3:0] m,
                        input logic [31:0] e);
    int n;
    n = 0;
    rp_valid = 1'b1;
    rp_write = w;
    rp_addr = a;
    rp_wdata = d;
    rp_mask = m;
    while (rp_ready !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    if (!w) begin
      rp_valid = 1'b0;
      while (rp_rdv !== 1'b1 && n < 200) begin
        @(posedge mclk);
        #1;
        n++;
      end
      check(rp_rdata, e);
    end
    if (n == 200) check(32'h0, 32'h1);
  endtask
  task automatic drain();
    int n;
    n = 0;
    req_valid = 1'b0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(exp_q.size(), 32'h0);
    @(posedge mclk);
    #1;
  endtask
  // Every read answer is compared in order against what was queued
  initial begin
    forever begin
      @(posedge mclk);
      #1;
      if (rd_valid === 1'b1) begin
        if (exp_q.size() == 0) check(32'h1, 32'h0);
        else check({16'h0000, rd_data[15:0]}, {16'h0000, exp_q.pop_front()});
      end
    end
  end
  initial begin
    #400000;
    fails++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = 32'h0;
    req_mask = 4'hf;
    seen_full = 1'b0;
    rp_valid = 1'b0;
    rp_write = 1'b0;
    rp_addr = '0;
    rp_wdata = 32'h0;
    rp_mask = 4'hf;
    repeat (12) @(posedge mclk);
    #1;
    nrst = 1'b1;
    // The buffer shows ready one edge after release
    @(posedge mclk);
    #1;
    // Same row and column in all four banks
    for (int b = 0; b < 4; b++) wr(ua(13'h0005, b[1:0], 10'h010), 16'h1100 + 16'(b), 2'h0);
    for (int b = 0; b < 4; b++) rd(ua(13'h0005, b[1:0], 10'h010), 2'h0, 16'h1100 + 16'(b));
    // Address extremes and a row change inside one bank
    wr(ua(13'h1fff, 2'h3, 10'h3ff), 16'hbeef, 2'h0);
    wr(ua(13'h0000, 2'h3, 10'h3fe), 16'h0f0f, 2'h0);
    wr(ua(13'h0001, 2'h0, 10'h007), 16'h2a2a, 2'h0);
    wr(ua(13'h0002, 2'h0, 10'h007), 16'h5b5b, 2'h0);
    rd(ua(13'h1fff, 2'h3, 10'h3ff), 2'h0, 16'hbeef);
    rd(ua(13'h0000, 2'h3, 10'h3fe), 2'h0, 16'h0f0f);
    rd(ua(13'h0001, 2'h0, 10'h007), 2'h0, 16'h2a2a);
    rd(ua(13'h0002, 2'h0, 10'h007), 2'h0, 16'h5b5b);
    drain();
    check({28'h0, bank_open}, 32'hf);
    // Byte masks on write and on read
    wr(ua(13'h0003, 2'h2, 10'h100), 16'ha5c3, 2'h0);
    wr(ua(13'h0003, 2'h2, 10'h100), 16'h1234, 2'h1);
    wr(ua(13'h0003, 2'h2, 10'h100), 16'h5678, 2'h2);
    wr(ua(13'h0003, 2'h2, 10'h100), 16'hffff, 2'h3);
    rd(ua(13'h0003, 2'h2, 10'h100), 2'h0, 16'h1278);
    rd(ua(13'h0003, 2'h2, 10'h100), 2'h1, 16'h1200);
    rd(ua(13'h0003, 2'h2, 10'h100), 2'h2, 16'h0078);
    rd(ua(13'h0003, 2'h2, 10'h100), 2'h3, 16'h0000);
    drain();
    // Eight back to back columns spaced 37 apart, written then read; the buffer must have refused at least once since reset
    for (int i = 0; i < 8; i++) wr(ua(13'h0003, 2'h1, 10'(i * 37)), 16'h3000 + 16'(i), 2'h0);
    for (int i = 0; i < 8; i++) rd(ua(13'h0003, 2'h1, 10'(i * 37)), 2'h0, 16'h3000 + 16'(i));
    drain();
    check({31'h0, seen_full}, 32'h1);
    // Full word, then lane 2 masked on write, then lane 0 masked on read
    put_rp(1'b1, {14'h2abc, 2'h2, 8'h5d}, 32'h01234567, 4'h0, 32'h0);
    put_rp(1'b1, {14'h2abc, 2'h2, 8'h5d}, 32'h89abcdef, 4'h4, 32'h0);
    put_rp(1'b0, {14'h2abc, 2'h2, 8'h5d}, 32'h0, 4'h1, 32'h8923cd00);
    check({28'h0, rp_open}, 32'h4);
    test_done();
  end
endmodule
`default_nettype wire
